/* dlm_pkg.sv */
// Package for the latency and drive mode register logic
package dlm_pkg;
    // Mode addresses
    localparam logic [5:0] MA_LATENCY = 6'h02;
    localparam logic [5:0] MA_DRIVE = 6'h03;
    localparam logic [5:0] MA_REPAIR = 6'h04;
    localparam logic [5:0] MA_SET_POINT = 6'h0D;
    // Latency register fields
    localparam int RL_LSB = 0;
    localparam int WL_LSB = 3;
    localparam int WLS_BIT = 6;
    localparam int WLEV_BIT = 7;
    // Drive register fields
    localparam int PUCAL_BIT = 0;
    localparam int WPST_BIT = 1;
    localparam int PROT_BIT = 2;
    localparam int PULLDOWN_DRIVE_STRENGTH_LSB = 3;
    localparam int RDBI_BIT = 6;
    localparam int WDBI_BIT = 7;
    // Repair and set point fields
    localparam int REPAIR_ENTRY_BIT = 4;
    localparam int WRITE_SET_POINT_SELECT_BIT = 6;
    localparam int OPERATING_SET_POINT_SELECT_BIT = 7;
    // Reset values; protection bit kept apart (power-on only)
    localparam logic [7:0] LATENCY_RST = 8'h00;
    localparam logic [7:0] DRIVE_RST = 8'h31;
    localparam logic [7:0] REPAIR_RST = 8'h00;
    localparam logic [7:0] SET_POINT_RST = 8'h00;
    // Burst length 32 extra read-to-precharge clocks
    localparam logic [5:0] BL32_RTP_EXTRA = 6'h08;
    // Command codes on the link
    typedef enum logic [1:0] {
        dlm_cmd_none_t = 2'h0,
        dlm_cmd_mrw = 2'h1,
        dlm_cmd_mrr = 2'h2
    } dlm_cmd_t;

    function automatic logic [5:0] read_latency(input logic [2:0] c, input logic dbi);
        logic [5:0] r;
        r = 6'h06;
        unique case (c)
            3'h0: r = 6'h06;
            3'h1: r = dbi ? 6'h0C : 6'h0A;
            3'h2: r = dbi ? 6'h10 : 6'h0E;
            3'h3: r = dbi ? 6'h16 : 6'h14;
            3'h4: r = dbi ? 6'h1C : 6'h18;
            3'h5: r = dbi ? 6'h20 : 6'h1C;
            3'h6: r = dbi ? 6'h24 : 6'h20;
            3'h7: r = dbi ? 6'h28 : 6'h24;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] write_latency(input logic [2:0] c, input logic set_b);
        logic [5:0] r;
        r = 6'h04;
        unique case (c)
            3'h0: r = 6'h04;
            3'h1: r = set_b ? 6'h08 : 6'h06;
            3'h2: r = set_b ? 6'h0C : 6'h08;
            3'h3: r = set_b ? 6'h12 : 6'h0A;
            3'h4: r = set_b ? 6'h16 : 6'h0C;
            3'h5: r = set_b ? 6'h1A : 6'h0E;
            3'h6: r = set_b ? 6'h1E : 6'h10;
            3'h7: r = set_b ? 6'h22 : 6'h12;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] write_recovery(input logic [2:0] c);
        logic [5:0] r;
        r = 6'h06;
        unique case (c)
            3'h0: r = 6'h06;
            3'h1: r = 6'h0A;
            3'h2: r = 6'h10;
            3'h3: r = 6'h14;
            3'h4: r = 6'h18;
            3'h5: r = 6'h1E;
            3'h6: r = 6'h22;
            3'h7: r = 6'h28;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] read_to_precharge(input logic [2:0] c);
        logic [5:0] r;
        r = 6'h08;
        unique case (c)
            3'h4: r = 6'h0A;
            3'h5: r = 6'h0C;
            3'h6: r = 6'h0E;
            3'h7: r = 6'h10;
            default: r = 6'h08;
        endcase
        return r;
    endfunction
endpackage

/* dlm_link_if.sv */
// Mode register command link between controller and device
`timescale 1ns/1ns
interface dlm_link_if (input wire logic link_clk);
    logic [1:0] cmd;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic refused;
    logic wlev_busy;
    modport dev (input link_clk, input cmd, input addr, input wdata,
                 output rdata, output rvalid, output refused, output wlev_busy);
    modport ctl (input link_clk, output cmd, output addr, output wdata,
                 input rdata, input rvalid, input refused, input wlev_busy);
endinterface

/* dlm_device.sv */
// Device end: dual set point mode registers and one shared auto precharge timer
`timescale 1ns/1ns
// Contract
// - Latency register fields at address 02H
// - Write leveling holds until cleared
// - Controller sends only clearing write then
// - Two copies; access via write set point
// - Operate from operating set point copy; leveling state taken from either copy
// - Read latency table by bus inversion
// - Write latency table by set select
// - Controller picks codes within frequency band
// - Write auto precharge waits recovery count
// - Read auto precharge waits read count
// - Burst 32 adds eight clocks
// - Drive register eight bits at 03H
// - Bits 6,7 enable bus inversion
// - Bit 1 selects write postamble length
// - Same calibration point on both channels
// - Protection bit sticky until power-on
// - Protection refuses repair entry write
module dlm_device (
    // Power-on reset, link clock domain
    input wire logic i_por,
    // Link
    dlm_link_if.dev link,
    // Core requests for auto precharge
    input wire logic i_wr_ap,
    input wire logic i_rd_ap,
    input wire logic i_bl32,
    // Operating values
    output logic [5:0] o_read_latency,
    output logic [5:0] o_write_latency,
    output logic o_rd_inv_en,
    output logic o_wr_inv_en,
    output logic o_long_postamble,
    output logic o_pullup_cal,
    output logic [2:0] o_pulldown_drive,
    output logic o_repair_mode,
    output logic o_precharge
);
    logic [7:0] lat_r [2];
    logic [7:0] drv_r [2];
    logic [7:0] sp_r;
    logic [7:0] rep_r;
    logic prot_r;
    logic [5:0] pre_cnt_r;
    logic pre_busy_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic refused_r;
    logic wsel;
    logic osel;
    logic is_mrw;
    logic is_mrr;
    logic [7:0] lat_op;
    logic [7:0] drv_op;
    logic [7:0] drv_rd;
    logic wlev_on;
    logic cmd_ok;
    logic wr_drv;
    logic rep_entry;

    assign wsel = sp_r[dlm_pkg::WRITE_SET_POINT_SELECT_BIT];
    assign osel = sp_r[dlm_pkg::OPERATING_SET_POINT_SELECT_BIT];
    assign is_mrw = link.cmd == dlm_pkg::dlm_cmd_mrw;
    assign is_mrr = link.cmd == dlm_pkg::dlm_cmd_mrr;
    assign lat_op = lat_r[osel];
    assign drv_op = drv_r[osel];
    assign drv_rd = {drv_r[wsel][7:3], prot_r, drv_r[wsel][1:0]};

    ////////////////////////////////////////////////////////////////////
    // Command decode
    // leveling state held
    assign wlev_on = lat_r[osel][dlm_pkg::WLEV_BIT] | lat_r[wsel][dlm_pkg::WLEV_BIT];
    assign cmd_ok = !wlev_on || (is_mrw && link.addr == dlm_pkg::MA_LATENCY);
    assign wr_drv = is_mrw && cmd_ok && link.addr == dlm_pkg::MA_DRIVE;
    assign rep_entry = is_mrw && cmd_ok && link.addr == dlm_pkg::MA_REPAIR
        && link.wdata[dlm_pkg::REPAIR_ENTRY_BIT];

    ////////////////////////////////////////////////////////////////////
    // Mode register writes
    // write selected copy
    always_ff @(posedge link.link_clk) begin
        if (i_por) begin
            lat_r[0] <= dlm_pkg::LATENCY_RST;
            lat_r[1] <= dlm_pkg::LATENCY_RST;
            drv_r[0] <= dlm_pkg::DRIVE_RST;
            drv_r[1] <= dlm_pkg::DRIVE_RST;
            sp_r <= dlm_pkg::SET_POINT_RST;
            rep_r <= dlm_pkg::REPAIR_RST;
        end else if (is_mrw && cmd_ok) begin
            unique case (link.addr)
                dlm_pkg::MA_LATENCY: lat_r[wsel] <= link.wdata;
                dlm_pkg::MA_DRIVE: drv_r[wsel] <= link.wdata;
                dlm_pkg::MA_SET_POINT: sp_r <= link.wdata;
                dlm_pkg::MA_REPAIR: begin
                    if (!(prot_r && link.wdata[dlm_pkg::REPAIR_ENTRY_BIT])) begin
                        rep_r <= link.wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (i_por) begin
            prot_r <= 1'b0;
        end else if (wr_drv && link.wdata[dlm_pkg::PROT_BIT]) begin
            // Set only; power-on alone clears it
            prot_r <= 1'b1;
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (i_por) begin
            refused_r <= 1'b0;
        end else begin
            refused_r <= rep_entry && prot_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode register reads, data one link clock later
    // read selected copy
    always_ff @(posedge link.link_clk) begin
        if (i_por) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= is_mrr && cmd_ok;
            if (is_mrr && cmd_ok) begin
                unique case (link.addr)
                    dlm_pkg::MA_LATENCY: rdata_r <= lat_r[wsel];
                    dlm_pkg::MA_DRIVE: rdata_r <= drv_rd;
                    dlm_pkg::MA_SET_POINT: rdata_r <= sp_r;
                    dlm_pkg::MA_REPAIR: rdata_r <= rep_r;
                    default: rdata_r <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Auto precharge timer
    always_ff @(posedge link.link_clk) begin
        if (i_por) begin
            pre_cnt_r <= 6'h00;
            pre_busy_r <= 1'b0;
        end else if (i_wr_ap) begin
            pre_cnt_r <= dlm_pkg::write_recovery(lat_op[dlm_pkg::RL_LSB +: 3]);
            pre_busy_r <= 1'b1;
        end else if (i_rd_ap) begin
            pre_cnt_r <= dlm_pkg::read_to_precharge(lat_op[dlm_pkg::RL_LSB +: 3])
                + (i_bl32 ? dlm_pkg::BL32_RTP_EXTRA : 6'h00);
            pre_busy_r <= 1'b1;
        end else if (pre_busy_r) begin
            pre_cnt_r <= pre_cnt_r - 6'h01;
            if (pre_cnt_r == 6'h01) begin
                pre_busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operating outputs
    // operate from active copy
    always_ff @(posedge link.link_clk) begin
        if (i_por) begin
            o_read_latency <= 6'h06;
            o_write_latency <= 6'h04;
            o_rd_inv_en <= 1'b0;
            o_wr_inv_en <= 1'b0;
            o_long_postamble <= 1'b0;
            o_pullup_cal <= 1'b1;
            o_pulldown_drive <= 3'h6;
            o_repair_mode <= 1'b0;
            o_precharge <= 1'b0;
        end else begin
            o_read_latency <= dlm_pkg::read_latency(lat_op[dlm_pkg::RL_LSB +: 3],
                drv_op[dlm_pkg::RDBI_BIT]);
            o_write_latency <= dlm_pkg::write_latency(lat_op[dlm_pkg::WL_LSB +: 3],
                lat_op[dlm_pkg::WLS_BIT]);
            o_rd_inv_en <= drv_op[dlm_pkg::RDBI_BIT];
            o_wr_inv_en <= drv_op[dlm_pkg::WDBI_BIT];
            o_long_postamble <= drv_op[dlm_pkg::WPST_BIT];
            o_pullup_cal <= drv_op[dlm_pkg::PUCAL_BIT];
            o_pulldown_drive <= drv_op[dlm_pkg::PULLDOWN_DRIVE_STRENGTH_LSB +: 3];
            o_repair_mode <= rep_r[dlm_pkg::REPAIR_ENTRY_BIT];
            o_precharge <= pre_busy_r && pre_cnt_r == 6'h01;
        end
    end

    assign link.rdata = rdata_r;
    assign link.rvalid = rvalid_r;
    assign link.refused = refused_r;
    // Leveling state to the controller
    assign link.wlev_busy = wlev_on;
endmodule // dlm_device

/* dlm_controller.sv */
// Controller end: software port to mode register commands
`timescale 1ns/1ns
module dlm_controller (
    // System clock and reset, plus link domain reset
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_link_reset,
    // Software port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Link
    dlm_link_if.ctl link
);
    // Own register map: command, status
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // System domain: request word and toggle
    logic [16:0] req_r;
    logic req_tgl_r;
    logic [1:0] ack_sync_r;
    logic [7:0] rd_hold_r;
    logic [1:0] busy_sync_r, refused_sync_r;
    logic [1:0] req_sync_r;
    logic req_seen_r, ack_tgl_r;
    logic link_init_r;
    logic [1:0] done_r;
    logic new_req;
    logic [7:0] rdata_l_r;
    logic refused_l_r;
    logic pending;

    assign pending = req_tgl_r != ack_sync_r[1];

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            req_r <= 17'h00000;
            req_tgl_r <= 1'b0;
        end else if (i_wr && i_addr == REG_CMD && !pending) begin
            // Bits 7:0 data, 13:8 address, 14 read
            req_r <= {1'b0, i_wdata};
            req_tgl_r <= ~req_tgl_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ack_sync_r <= 2'h0;
            rd_hold_r <= 8'h00;
            busy_sync_r <= 2'h0;
            refused_sync_r <= 2'h0;
            o_rdata <= 16'h0000;
        end else begin
            ack_sync_r <= {ack_sync_r[0], ack_tgl_r};
            busy_sync_r <= {busy_sync_r[0], link.wlev_busy};
            refused_sync_r <= {refused_sync_r[0], refused_l_r};
            // Link data settles before the acknowledge returns
            if (!pending) begin
                rd_hold_r <= rdata_l_r;
            end
            o_rdata <= 16'h0000;
            if (i_rd && i_addr == REG_STATUS) begin
                o_rdata <= {5'h00, refused_sync_r[1], busy_sync_r[1], pending, rd_hold_r};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link domain: issue at most one command per request
    always_ff @(posedge link.link_clk) begin
        req_sync_r <= {req_sync_r[0], req_tgl_r};
    end

    // No replay of the toggle state left over from before a link reset
    assign new_req = !link_init_r && req_sync_r[1] != req_seen_r;

    always_ff @(posedge link.link_clk) begin
        if (i_link_reset) begin
            req_seen_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            link_init_r <= 1'b1;
            done_r <= 2'h0;
            link.cmd <= 2'h0;
            link.addr <= 6'h00;
            link.wdata <= 8'h00;
            rdata_l_r <= 8'h00;
            refused_l_r <= 1'b0;
        end else begin
            link_init_r <= 1'b0;
            done_r <= {done_r[0], new_req};
            link.cmd <= 2'h0;
            if (link.rvalid) begin
                rdata_l_r <= link.rdata;
            end
            if (link.refused) begin
                refused_l_r <= 1'b1;
            end
            if (link_init_r || new_req) begin
                req_seen_r <= req_sync_r[1];
            end
            // Acknowledge once read data and refusal have landed
            if (link_init_r) begin
                ack_tgl_r <= req_sync_r[1];
            end else if (done_r[1]) begin
                ack_tgl_r <= req_seen_r;
            end
            if (new_req) begin
                if (!link.wlev_busy || (!req_r[14] && req_r[13:8] == dlm_pkg::MA_LATENCY
                    && !req_r[dlm_pkg::WLEV_BIT])) begin
                    link.cmd <= req_r[14] ? 2'h2 : 2'h1;
                    link.addr <= req_r[13:8];
                    link.wdata <= req_r[7:0];
                end
            end
        end
    end
endmodule // dlm_controller

/* dlm_link_properties.sv */
// Checker for the mode register link between controller and device
`timescale 1ns/1ns
module dlm_link_properties (
    // Link clock and power-on reset
    input wire logic link_clk,
    input wire logic i_por,
    // Controller to device
    input wire logic [1:0] cmd,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    // Device to controller
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic refused,
    input wire logic wlev_busy
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (i_por);
    wire is_wr = cmd == dlm_pkg::dlm_cmd_mrw;
    wire is_rd = cmd == dlm_pkg::dlm_cmd_mrr;
    wire lev_wr = is_wr && addr == dlm_pkg::MA_LATENCY;
    wire rep_entry = is_wr && addr == dlm_pkg::MA_REPAIR && wdata[dlm_pkg::REPAIR_ENTRY_BIT];
    ////////////////////////////////////////////////////////////////////////////////
    property p_read_answer;
        is_rd |=> rvalid ##1 !rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_answer_cause;
        rvalid |-> $past(is_rd);
    endproperty
    a_answer_cause: assert property (p_answer_cause) else $error("answer without read");
    property p_rdata_hold;
        $changed(rdata) |-> rvalid;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_lev_enter;
        lev_wr && wdata[dlm_pkg::WLEV_BIT] |=> wlev_busy;
    endproperty
    a_lev_enter: assert property (p_lev_enter) else $error("leveling not entered");
    property p_lev_hold;
        wlev_busy && !lev_wr |=> wlev_busy;
    endproperty
    a_lev_hold: assert property (p_lev_hold) else $error("leveling left early");
    property p_lev_only_clear;
        wlev_busy |-> cmd == dlm_pkg::dlm_cmd_none_t || (lev_wr && !wdata[dlm_pkg::WLEV_BIT]);
    endproperty
    a_lev_only_clear: assert property (p_lev_only_clear) else $error("leveling command");
    property p_refuse_cause;
        refused |-> $past(rep_entry);
    endproperty
    a_refuse_cause: assert property (p_refuse_cause) else $error("stray refusal");
    property p_refuse_pulse;
        refused |=> !refused;
    endproperty
    a_refuse_pulse: assert property (p_refuse_pulse) else $error("refusal too long");
    c_level: cover property (lev_wr && wdata[dlm_pkg::WLEV_BIT]);
    c_refuse: cover property (refused);
    c_read: cover property (rvalid);
endmodule // dlm_link_properties

/* tb.sv */
// Testbench joining controller and device over the mode register link
`timescale 1ns/1ns
module tb;
    logic i_clk, link_clk, i_reset, i_por, i_link_reset, i_wr, i_rd, i_wr_ap, i_rd_ap, i_bl32;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, o_rdata, stat;
    logic [5:0] o_read_latency, o_write_latency;
    logic o_rd_inv_en, o_wr_inv_en, o_long_postamble, o_pullup_cal, o_repair_mode, o_precharge;
    logic [2:0] o_pulldown_drive;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    localparam int RL_OFF [8] = '{6, 10, 14, 20, 24, 28, 32, 36};
    localparam int RL_ON [8] = '{6, 12, 16, 22, 28, 32, 36, 40};
    localparam int WL_A [8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    localparam int WL_B [8] = '{4, 8, 12, 18, 22, 26, 30, 34};
    localparam int WRITE_RECOVERY_COUNT [8] = '{6, 10, 16, 20, 24, 30, 34, 40};
    localparam int READ_TO_PRECHARGE_COUNT [8] = '{8, 8, 8, 8, 10, 12, 14, 16};
    dlm_link_if lnk (.link_clk(link_clk));
    dlm_controller i_dlm_controller (.i_clk(i_clk), .i_reset(i_reset),
        .i_link_reset(i_link_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .link(lnk));
    dlm_device i_dlm_device (.i_por(i_por), .link(lnk), .i_wr_ap(i_wr_ap), .i_rd_ap(i_rd_ap),
        .i_bl32(i_bl32), .o_read_latency(o_read_latency), .o_write_latency(o_write_latency),
        .o_rd_inv_en(o_rd_inv_en), .o_wr_inv_en(o_wr_inv_en),
        .o_long_postamble(o_long_postamble), .o_pullup_cal(o_pullup_cal),
        .o_pulldown_drive(o_pulldown_drive), .o_repair_mode(o_repair_mode),
        .o_precharge(o_precharge));
    dlm_link_properties i_dlm_link_properties (.link_clk(link_clk), .i_por(i_por),
        .cmd(lnk.cmd), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
        .rvalid(lnk.rvalid), .refused(lnk.refused), .wlev_busy(lnk.wlev_busy));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'h0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        link_clk = 1'h0;
        #17;
        forever begin
            #62 link_clk = ~link_clk;
            #63 link_clk = ~link_clk;
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask
    task automatic sw_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1 d = o_rdata;
    endtask
    // Issue one command word, wait for completion, then fetch status
    task automatic mr(input logic [15:0] w);
        sw_wr(8'h00, w);
        stat = 16'h0100;
        for (int k = 0; k < 80 && stat[8] !== 1'h0; k++) begin
            sw_rd(8'h04, stat);
        end
        chk("pending", stat[8], 16'h0000);
        repeat (3) @(posedge link_clk);
        sw_rd(8'h04, stat);
    endtask
    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        mr({2'h0, a, d});
    endtask
    task automatic mrr(input logic [5:0] a, input logic [7:0] e, input string n);
        mr({2'h1, a, 8'h00});
        chk(n, stat[7:0], e);
    endtask
    task automatic pre(input logic wr, input logic bl, input int n);
        int k;
        @(posedge link_clk);
        i_wr_ap <= wr;
        i_rd_ap <= !wr;
        i_bl32 <= bl;
        @(posedge link_clk);
        i_wr_ap <= 1'h0;
        i_rd_ap <= 1'h0;
        i_bl32 <= 1'h0;
        k = 0;
        do begin
            @(posedge link_clk);
            k++;
            #1;
        end while (o_precharge !== 1'h1 && k < 60);
        chk("precharge delay", k, n);
    endtask
    task automatic link_rst(input logic p);
        @(posedge link_clk);
        i_link_reset <= 1'h1;
        i_por <= p;
        repeat (3) @(posedge link_clk);
        i_link_reset <= 1'h0;
        i_por <= 1'h0;
        repeat (2) @(posedge link_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        chk("latencies", {o_read_latency, o_write_latency}, 16'h0184);
        chk("flags", {o_wr_inv_en, o_rd_inv_en, o_long_postamble, o_repair_mode}, 16'h0000);
        chk("drive", {o_pullup_cal, o_pulldown_drive}, 16'h000E);
        sw_rd(8'h08, stat);
        chk("unmapped", stat, 16'h0000);
        mrr(dlm_pkg::MA_DRIVE, 8'h31, "drive reg");
    endtask
    task automatic t_latency;
        for (int c = 0; c < 8; c++) begin
            for (int v = 0; v < 2; v++) begin
                mrw(dlm_pkg::MA_DRIVE, v ? 8'h71 : 8'h31);
                mrw(dlm_pkg::MA_LATENCY, {1'h0, v[0], c[2:0], c[2:0]});
                chk("read latency", o_read_latency, v ? RL_ON[c] : RL_OFF[c]);
                chk("write latency", o_write_latency, v ? WL_B[c] : WL_A[c]);
                mrr(dlm_pkg::MA_LATENCY, {1'h0, v[0], c[2:0], c[2:0]}, "latency");
            end
            pre(1'h1, 1'h0, WRITE_RECOVERY_COUNT[c]);
            pre(1'h0, 1'h0, READ_TO_PRECHARGE_COUNT[c]);
            pre(1'h0, 1'h1, READ_TO_PRECHARGE_COUNT[c] + 8);
        end
    endtask
    task automatic t_set_point;
        mrw(dlm_pkg::MA_SET_POINT, 8'h40);
        mrw(dlm_pkg::MA_LATENCY, 8'h12);
        chk("latencies", {o_read_latency, o_write_latency}, 16'h0A22);
        mrr(dlm_pkg::MA_LATENCY, 8'h12, "copy one");
        mrw(dlm_pkg::MA_SET_POINT, 8'h00);
        mrr(dlm_pkg::MA_LATENCY, 8'h7F, "copy zero");
        mrw(dlm_pkg::MA_SET_POINT, 8'h80);
        chk("latencies", {o_read_latency, o_write_latency}, 16'h0388);
        mrw(dlm_pkg::MA_SET_POINT, 8'h00);
    endtask
    task automatic t_drive;
        mrw(dlm_pkg::MA_DRIVE, 8'hD2);
        chk("inversion", {o_wr_inv_en, o_rd_inv_en}, 16'h0003);
        chk("postamble", o_long_postamble, 16'h0001);
        chk("drive", {o_pullup_cal, o_pulldown_drive}, 16'h0002);
        mrr(dlm_pkg::MA_DRIVE, 8'hD2, "drive reg");
    endtask
    task automatic t_leveling;
        mrw(dlm_pkg::MA_LATENCY, 8'h80);
        chk("leveling", stat[9], 16'h0001);
        mrw(dlm_pkg::MA_DRIVE, 8'h00);
        mrr(dlm_pkg::MA_DRIVE, 8'hD2, "dropped read");
        chk("leveling", stat[9], 16'h0001);
        mrw(dlm_pkg::MA_LATENCY, 8'h00);
        chk("leveling", stat[9], 16'h0000);
        mrr(dlm_pkg::MA_DRIVE, 8'hD2, "drive reg");
    endtask
    task automatic t_protect;
        mrw(dlm_pkg::MA_REPAIR, 8'h10);
        chk("repair", o_repair_mode, 16'h0001);
        mrw(dlm_pkg::MA_REPAIR, 8'h00);
        mrw(dlm_pkg::MA_DRIVE, 8'hD6);
        mrw(dlm_pkg::MA_DRIVE, 8'hD2);
        mrr(dlm_pkg::MA_DRIVE, 8'hD6, "sticky bit");
        mrw(dlm_pkg::MA_REPAIR, 8'h10);
        chk("refused", {o_repair_mode, stat[10]}, 16'h0001);
        link_rst(1'h0);
        sw_rd(8'h04, stat);
        chk("refused", stat[10], 16'h0000);
        mrw(dlm_pkg::MA_REPAIR, 8'h10);
        chk("refused", {o_repair_mode, stat[10]}, 16'h0001);
        link_rst(1'h1);
        mrr(dlm_pkg::MA_DRIVE, 8'h31, "after power on");
        mrw(dlm_pkg::MA_REPAIR, 8'h10);
        chk("repair", o_repair_mode, 16'h0001);
    endtask
    initial begin
        i_reset = 1'h1;
        i_por = 1'h1;
        i_link_reset = 1'h1;
        {i_addr, i_wdata, i_wr, i_rd, i_wr_ap, i_rd_ap, i_bl32} = '0;
        stat = 16'h0000;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'h0;
        i_por <= 1'h0;
        i_link_reset <= 1'h0;
        repeat (3) @(posedge link_clk);
        t_defaults();
        t_latency();
        t_set_point();
        t_drive();
        t_leveling();
        t_protect();
        summarize();
    end
endmodule // tb
